// *** shared/afc_pkg.sv ***
/*
 Constants, types and carriers for the converter front-end control block.
 Assumes one master clock domain; register bus index is 4 bits, data 8 bits.
*/
`default_nettype none
package afc_pkg;
    // ==========================================================
    // Clocking and filter
    localparam int MASTER_HZ     = 2457600;
    localparam int MOD_HZ        = 19200;
    localparam int DATA_RATE_CHZ = 1500;
    localparam int FIR_TAPS      = 1279;
    localparam int MOD_DIV_BASE  = MASTER_HZ / MOD_HZ;
    localparam int CONV_MOD_BASE = MOD_HZ * 100 / DATA_RATE_CHZ;
    localparam logic [1:0] CAL_PERIODS = 2'h2;
    // ==========================================================
    // Register indices
    localparam logic [3:0] A_SETUP = 4'h0;
    localparam logic [3:0] A_ACR   = 4'h2;
    localparam logic [3:0] A_OFS   = 4'h3;
    localparam logic [3:0] A_DIO   = 4'h4;
    localparam logic [3:0] A_DIR   = 4'h5;
    localparam logic [3:0] A_FUNC  = 4'h6;
    localparam logic [3:0] A_CMD   = 4'h8;
    localparam logic [3:0] A_RES2  = 4'h9;
    localparam logic [3:0] A_RES1  = 4'hA;
    localparam logic [3:0] A_RES0  = 4'hB;
    localparam logic [3:0] A_SPI   = 4'hC;
    // ==========================================================
    // Field positions
    localparam int SETUP_SENSOR_BREAK_CURRENT_ENABLE = 3;
    localparam int ACR_RDY    = 7;
    localparam int ACR_SPEED  = 5;
    localparam int ACR_INPUT_BUFFER_ENABLE  = 4;
    localparam int ACR_RANGE  = 2;
    // ==========================================================
    // Commands and values
    localparam logic [7:0] CMD_SELF_FULL = 8'h01;
    localparam logic [7:0] CMD_SELF_GAIN = 8'h02;
    localparam logic [7:0] CMD_SELF_OFS  = 8'h03;
    localparam logic [7:0] CMD_SYS_OFS   = 8'h04;
    localparam logic [7:0] CMD_SYS_GAIN  = 8'h05;
    localparam logic [23:0] FULL_SCALE   = 24'h7FFFFF;
    localparam logic [7:0] RST_DIR       = 8'hFF;
    localparam logic [7:0] RST_FUNC      = 8'h00;
    localparam logic [2:0] RST_GAIN      = 3'h0;
    localparam logic [7:0] RST_GFACT     = 8'h01;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_OFS  = 3'b010,
        CAL_GAIN = 3'b100
    } afc_cal_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } afc_bus_t;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] val;
    } afc_dio_t;

    typedef struct packed {
        logic [1:0]  input_buffer_enable_s;
        logic [1:0]  pol_s;
        logic [2:0]  sclk_s;
        logic [1:0]  din_s;
        logic [1:0]  cs_s;
        logic [1:0]  open_s;
        logic [7:0]  dio_s1;
        logic [7:0]  dio_s2;
        logic        sensor_break_current_enable;
        logic [2:0]  gain;
        logic [7:0]  gfact;
        logic        speed;
        logic        input_buffer_enable;
        logic        range;
        logic [1:0]  rate;
        logic        buf_on;
        logic [7:0]  ofs;
        logic [7:0]  dout;
        logic [7:0]  dir;
        logic [7:0]  func;
        afc_dio_t    drv;
        logic [7:0]  rdata;
        logic [8:0]  div_cnt;
        logic [12:0] per_cnt;
        logic [23:0] acc;
        logic [23:0] result;
        logic        rdy_n;
        logic [23:0] ofs_coef;
        logic [23:0] gain_coef;
        afc_cal_t    cal;
        logic        cal_both;
        logic        cal_self;
        logic [1:0]  cal_left;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_cnt;
        logic [7:0]  rx_byte;
    } afc_state_t;
endpackage : afc_pkg
`default_nettype wire

// *** rtl/afc_frontend.sv ***
/*
 Front-end control of a delta-sigma converter: setup, buffer, gain, offset
 correction, modulator divider, decimation timing, calibration sequencing,
 dual-purpose pins and the slave-only serial receiver.
 Assumes mclk_i is the master clock and the modulator bitstream is synchronous.
*/
// The strobed register port and the address map were chosen for this implementation.
// What this block does
// - Sensor-break bit switches both input current sources on, clear switches off.
// - Open sensor with sources on reports positive full-scale code.
// - Buffer on only when buffer pin high and buffer bit one.
// - Eight selectable gains, powers of two from 1 to 128.
// - Offset value is 8-bit sign-magnitude, bit 7 direction.
// - Modulator clock is master clock divided; speed bit halves it.
// - Rate codes 00, 01, 10 give full, half and quarter output rate.
// - Decimation sums 1279 modulator bits per 1280-sample window, the last bit is dropped; rate tracks master clock.
// - Full, gain-only and offset-only self calibration; single ones take two periods.
// - System offset and gain calibration, two periods each.
// - Calibration end drives result-ready low.
// - Each pin selectable analog or digital; analog after reset.
// - Analog pin ignores its direction and data bits.
// - Digital input pin returns sampled level in data bit.
// - Digital output pin driven from its data bit.
// - Digital pins can still be converted as a test mode.
// - Serial port is slave only, never makes a clock.
// - Serial port supports both clock polarities via polarity pin.
// - Polarity low samples falling edge, high samples rising edge.
// - Result-ready state mirrored in bit 7 of analog control word.
// - Gain field is power-of-two exponent, 000 is gain 1 default.
`default_nettype none
module afc_frontend #(
    parameter int MOD_DIV  = afc_pkg::MOD_DIV_BASE,
    parameter int CONV_MOD = afc_pkg::CONV_MOD_BASE
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    input  wire logic            ce_i,
    input  wire afc_pkg::afc_bus_t bus_i,
    output logic [7:0]           rd_data_o,
    input  wire logic            buf_pin_i,
    input  wire logic            sensor_open_i,
    input  wire logic            mod_bit_i,
    input  wire logic [7:0]      dio_i,
    output afc_pkg::afc_dio_t    dio_o,
    input  wire logic            sclk_i,
    input  wire logic            pol_i,
    input  wire logic            sdin_i,
    input  wire logic            cs_n_i,
    output logic                 result_ready_n_o,
    output logic                 burnout_pos_o,
    output logic                 burnout_neg_o,
    output logic                 buffer_on_o,
    output logic [7:0]           gain_factor_o,
    output logic                 offset_neg_o,
    output logic [6:0]           offset_mag_o,
    output logic                 cal_internal_o,
    output logic [23:0]          result_o,
    output logic [23:0]          gain_coef_o
);
    // ==========================================================
    // State
    afc_pkg::afc_state_t st_reg;
    afc_pkg::afc_state_t st_next;

    logic [8:0]  div_lim;
    logic [12:0] per_lim;
    logic        mod_tick;
    logic        per_end;
    logic        sclk_act;
    logic [23:0] corr;

    function automatic logic [7:0] pin_read(input logic [7:0] func, input logic [7:0] dir,
                                            input logic [7:0] lvl, input logic [7:0] dat);
        pin_read = (func & dir & lvl) | (~(func & dir) & dat);
    endfunction : pin_read

    // ==========================================================
    // Timing
    // Rate code 11 is taken as the slowest rate
    always_comb
    begin
        div_lim  = 9'(MOD_DIV << st_reg.speed) - 9'h001;
        per_lim  = 13'(CONV_MOD << (st_reg.rate[1] ? 2 : st_reg.rate)) - 13'h0001;
        mod_tick = (st_reg.div_cnt == div_lim);
        per_end  = mod_tick && (st_reg.per_cnt == per_lim);
        // Active edge from the two settled stages only
        sclk_act = (st_reg.sclk_s[1] != st_reg.sclk_s[2]) && (st_reg.sclk_s[1] == st_reg.pol_s[1]);
        corr     = st_reg.acc - st_reg.ofs_coef;
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        st_next = st_reg;
        st_next.input_buffer_enable_s = {st_reg.input_buffer_enable_s[0], buf_pin_i};
        st_next.pol_s   = {st_reg.pol_s[0], pol_i};
        st_next.sclk_s  = {st_reg.sclk_s[1:0], sclk_i};
        st_next.din_s   = {st_reg.din_s[0], sdin_i};
        st_next.cs_s    = {st_reg.cs_s[0], cs_n_i};
        st_next.open_s  = {st_reg.open_s[0], sensor_open_i};
        st_next.dio_s1  = dio_i;
        st_next.dio_s2  = st_reg.dio_s1;

        // Register writes
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                afc_pkg::A_SETUP:
                begin
                    st_next.sensor_break_current_enable = bus_i.wdata[afc_pkg::SETUP_SENSOR_BREAK_CURRENT_ENABLE];
                    st_next.gain = bus_i.wdata[2:0];
                end
                afc_pkg::A_ACR:
                begin
                    st_next.speed = bus_i.wdata[afc_pkg::ACR_SPEED];
                    st_next.input_buffer_enable = bus_i.wdata[afc_pkg::ACR_INPUT_BUFFER_ENABLE];
                    st_next.range = bus_i.wdata[afc_pkg::ACR_RANGE];
                    st_next.rate  = bus_i.wdata[1:0];
                end
                afc_pkg::A_OFS:  st_next.ofs  = bus_i.wdata;
                afc_pkg::A_DIO:  st_next.dout = bus_i.wdata;
                afc_pkg::A_DIR:  st_next.dir  = bus_i.wdata;
                afc_pkg::A_FUNC: st_next.func = bus_i.wdata;
                default: ;
            endcase
        end
        st_next.gfact = 8'(8'h01 << st_next.gain);

        // Register reads, data valid the cycle after the strobe
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                afc_pkg::A_SETUP: st_next.rdata = {4'h0, st_reg.sensor_break_current_enable, st_reg.gain};
                afc_pkg::A_ACR:   st_next.rdata = {st_reg.rdy_n, 1'b0, st_reg.speed, st_reg.input_buffer_enable,
                                                   1'b0, st_reg.range, st_reg.rate};
                afc_pkg::A_OFS:   st_next.rdata = st_reg.ofs;
                afc_pkg::A_DIO:   st_next.rdata = pin_read(st_reg.func, st_reg.dir,
                                                           st_reg.dio_s2, st_reg.dout);
                afc_pkg::A_DIR:   st_next.rdata = st_reg.dir;
                afc_pkg::A_FUNC:  st_next.rdata = st_reg.func;
                afc_pkg::A_RES2:  st_next.rdata = st_reg.result[23:16];
                afc_pkg::A_RES1:  st_next.rdata = st_reg.result[15:8];
                afc_pkg::A_RES0:  st_next.rdata = st_reg.result[7:0];
                afc_pkg::A_SPI:   st_next.rdata = st_reg.rx_byte;
                default:          st_next.rdata = 8'h00;
            endcase
            if (bus_i.addr == afc_pkg::A_RES0)
            begin
                st_next.rdy_n = 1'b1;
            end
        end

        // Pins: analog pins stay undriven whatever dir and data hold
        st_next.drv.oe  = st_next.func & ~st_next.dir;
        st_next.drv.val = st_next.func & ~st_next.dir & st_next.dout;
        st_next.buf_on  = st_reg.input_buffer_enable_s[1] & st_next.input_buffer_enable;

        // Modulator divider and decimation window
        st_next.div_cnt = mod_tick ? 9'h000 : st_reg.div_cnt + 9'h001;
        if (mod_tick)
        begin
            // Pin function does not gate the converter path
            st_next.acc     = st_reg.acc + (mod_bit_i ? 24'h000001 : 24'hFFFFFF);
            st_next.per_cnt = per_end ? 13'h0000 : st_reg.per_cnt + 13'h0001;
        end
        if (per_end)
        begin
            st_next.acc = 24'h000000;
            unique case (st_reg.cal)
                afc_pkg::CAL_IDLE:
                begin
                    st_next.result = (st_reg.sensor_break_current_enable && st_reg.open_s[1]) ? afc_pkg::FULL_SCALE : corr;
                    st_next.rdy_n  = 1'b0;
                end
                afc_pkg::CAL_OFS:
                begin
                    st_next.cal_left = st_reg.cal_left - 2'h1;
                    if (st_reg.cal_left == 2'h1)
                    begin
                        st_next.ofs_coef = st_reg.acc;
                        st_next.cal_left = afc_pkg::CAL_PERIODS;
                        st_next.cal      = st_reg.cal_both ? afc_pkg::CAL_GAIN : afc_pkg::CAL_IDLE;
                        st_next.rdy_n    = st_reg.cal_both;
                    end
                end
                afc_pkg::CAL_GAIN:
                begin
                    st_next.cal_left = st_reg.cal_left - 2'h1;
                    if (st_reg.cal_left == 2'h1)
                    begin
                        st_next.gain_coef = corr;
                        st_next.cal       = afc_pkg::CAL_IDLE;
                        st_next.rdy_n     = 1'b0;
                    end
                end
            endcase
        end

        // Calibration commands restart the window so periods are whole
        if (bus_i.wr && bus_i.addr == afc_pkg::A_CMD)
        begin
            st_next.cal_left = afc_pkg::CAL_PERIODS;
            st_next.cal_both = 1'b0;
            st_next.cal_self = 1'b1;
            unique case (bus_i.wdata)
                afc_pkg::CMD_SELF_FULL:
                begin
                    st_next.cal      = afc_pkg::CAL_OFS;
                    st_next.cal_both = 1'b1;
                end
                afc_pkg::CMD_SELF_GAIN: st_next.cal = afc_pkg::CAL_GAIN;
                afc_pkg::CMD_SELF_OFS:  st_next.cal = afc_pkg::CAL_OFS;
                afc_pkg::CMD_SYS_OFS:
                begin
                    st_next.cal      = afc_pkg::CAL_OFS;
                    st_next.cal_self = 1'b0;
                end
                afc_pkg::CMD_SYS_GAIN:
                begin
                    st_next.cal      = afc_pkg::CAL_GAIN;
                    st_next.cal_self = 1'b0;
                end
                default: st_next.cal_left = st_reg.cal_left;
            endcase
            if (st_next.cal != afc_pkg::CAL_IDLE)
            begin
                st_next.acc     = 24'h000000;
                st_next.per_cnt = 13'h0000;
                st_next.div_cnt = 9'h000;
            end
        end
        if (st_next.cal != afc_pkg::CAL_IDLE)
        begin
            st_next.rdy_n = 1'b1;
        end
        else
        begin
            st_next.cal_self = 1'b0;
        end

        // Serial receiver, sampled only; no clock is ever driven
        if (st_reg.cs_s[1])
        begin
            st_next.rx_cnt = 3'h0;
        end
        else if (sclk_act)
        begin
            st_next.rx_sh  = {st_reg.rx_sh[6:0], st_reg.din_s[1]};
            st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
            if (st_reg.rx_cnt == 3'h7)
            begin
                st_next.rx_byte = {st_reg.rx_sh[6:0], st_reg.din_s[1]};
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_reg       <= '0;
            st_reg.gain  <= afc_pkg::RST_GAIN;
            st_reg.gfact <= afc_pkg::RST_GFACT;
            st_reg.dir   <= afc_pkg::RST_DIR;
            st_reg.func  <= afc_pkg::RST_FUNC;
            st_reg.rdy_n <= 1'b1;
            st_reg.cal   <= afc_pkg::CAL_IDLE;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o        = st_reg.rdata;
    assign dio_o            = st_reg.drv;
    assign result_ready_n_o = st_reg.rdy_n;
    assign burnout_pos_o    = st_reg.sensor_break_current_enable;
    assign burnout_neg_o    = st_reg.sensor_break_current_enable;
    assign buffer_on_o      = st_reg.buf_on;
    assign gain_factor_o    = st_reg.gfact;
    assign offset_neg_o     = st_reg.ofs[7];
    assign offset_mag_o     = st_reg.ofs[6:0];
    assign cal_internal_o   = st_reg.cal_self;
    assign result_o         = st_reg.result;
    assign gain_coef_o      = st_reg.gain_coef;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_cal_last;
        ce_i && per_end && st_reg.cal_left == 2'h1 &&
        (st_reg.cal == afc_pkg::CAL_GAIN || (st_reg.cal == afc_pkg::CAL_OFS && !st_reg.cal_both));
    endsequence
    sequence s_cmd_start;
        ce_i && bus_i.wr && bus_i.addr == afc_pkg::A_CMD &&
        bus_i.wdata >= afc_pkg::CMD_SELF_FULL && bus_i.wdata <= afc_pkg::CMD_SYS_GAIN;
    endsequence
    sequence s_last_bit;
        ce_i && !st_reg.cs_s[1] && sclk_act && st_reg.rx_cnt == 3'h7;
    endsequence
    sequence s_open_end;
        ce_i && per_end && st_reg.cal == afc_pkg::CAL_IDLE && st_reg.sensor_break_current_enable && st_reg.open_s[1];
    endsequence

    AST_CAL_DONE: assert property (s_cal_last |=> !result_ready_n_o ##0 st_reg.cal == afc_pkg::CAL_IDLE)
        else $error("calibration end did not flag result ready");
    AST_FULL_SCALE: assert property (s_open_end |=> result_o == afc_pkg::FULL_SCALE && !result_ready_n_o)
        else $error("open sensor did not give full scale");
    AST_CAL_BUSY: assert property (st_reg.cal != afc_pkg::CAL_IDLE |-> result_ready_n_o)
        else $error("result ready low during calibration");
    AST_BUFFER: assert property (ce_i |=> buffer_on_o == ($past(st_reg.input_buffer_enable_s[1]) && st_reg.input_buffer_enable))
        else $error("buffer enable mismatch");
    AST_GAIN: assert property (gain_factor_o == 8'(8'h01 << st_reg.gain) && $onehot(gain_factor_o))
        else $error("gain factor not two to the field");
    AST_ANALOG_PIN: assert property ((dio_o.oe & ~st_reg.func) == 8'h00)
        else $error("analog pin driven");
    AST_DIO_OUT: assert property (ce_i && !bus_i.wr |=> dio_o.oe == (st_reg.func & ~st_reg.dir) &&
                                  dio_o.val == (st_reg.func & ~st_reg.dir & st_reg.dout))
        else $error("output pin not following data bit");
    AST_DIO_IN: assert property (ce_i && bus_i.rd && bus_i.addr == afc_pkg::A_DIO && st_reg.func[0] && st_reg.dir[0]
                                 |=> rd_data_o[0] == $past(st_reg.dio_s2[0]))
        else $error("input pin level not returned");
    AST_ACR_RDY: assert property (ce_i && bus_i.rd && bus_i.addr == afc_pkg::A_ACR
                                  |=> rd_data_o[afc_pkg::ACR_RDY] == $past(result_ready_n_o))
        else $error("ready bit not mirrored");
    AST_FULL_SEQ: assert property (ce_i && bus_i.wr && bus_i.addr == afc_pkg::A_CMD &&
                                   bus_i.wdata == afc_pkg::CMD_SELF_FULL
                                   |=> st_reg.cal == afc_pkg::CAL_OFS && st_reg.cal_both)
        else $error("full calibration did not start with offset");
    // A new command must hide stale results at once, whatever phase was running
    AST_CMD_BUSY: assert property (s_cmd_start |=> result_ready_n_o && st_reg.cal != afc_pkg::CAL_IDLE)
        else $error("command did not start calibration");
    AST_SELF_FLAG: assert property (s_cmd_start
                                    |=> cal_internal_o == ($past(bus_i.wdata) <= afc_pkg::CMD_SELF_OFS))
        else $error("self calibration flag wrong");
    AST_BURNOUT: assert property (ce_i && bus_i.wr && bus_i.addr == afc_pkg::A_SETUP
                                  |=> burnout_pos_o == $past(bus_i.wdata[afc_pkg::SETUP_SENSOR_BREAK_CURRENT_ENABLE]) &&
                                      burnout_neg_o == $past(bus_i.wdata[afc_pkg::SETUP_SENSOR_BREAK_CURRENT_ENABLE]))
        else $error("current sources do not follow sensor-break bit");
    AST_OFS_VALUE: assert property (ce_i && bus_i.wr && bus_i.addr == afc_pkg::A_OFS
                                    |=> {offset_neg_o, offset_mag_o} == $past(bus_i.wdata))
        else $error("offset sign or magnitude wrong");
    AST_MOD_WRAP: assert property (ce_i && mod_tick |=> st_reg.div_cnt == 9'h000)
        else $error("modulator divider did not wrap");
    AST_RX_BYTE: assert property (s_last_bit
                                  |=> st_reg.rx_byte == $past({st_reg.rx_sh[6:0], st_reg.din_s[1]}))
        else $error("serial byte not loaded on eighth edge");
endmodule : afc_frontend
`default_nettype wire

// *** testbench/afc_host_model.sv ***
/*
 Host side of the serial port: a master that makes the serial clock.
 Assumes the device samples the pins through synchronisers on mclk_i.
*/
`default_nettype none
module afc_host_model (
    input  wire logic mclk_i,
    output logic      sclk_o,
    output logic      sdin_o,
    output logic      cs_n_o,
    output logic      pol_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        pol_o  = 1'b0;
        sclk_o = 1'b0;
        sdin_o = 1'b0;
        cs_n_o = 1'b1;
    end

    // ==========================================================
    // Byte transfer
    // Four master cycles per half period, slower than the 3-stage synchroniser
    task automatic send(input logic clock_polarity_select, input logic [7:0] data);
        pol_o  <= clock_polarity_select;
        sclk_o <= clock_polarity_select;
        repeat (6) @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            repeat (4) @(posedge mclk_i);
            sdin_o <= data[i];
            sclk_o <= ~clock_polarity_select;
            repeat (4) @(posedge mclk_i);
            sclk_o <= clock_polarity_select;
        end
        repeat (6) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        // Released line must not keep showing the last bit
        sdin_o <= ~data[0];
    endtask : send
endmodule : afc_host_model
`default_nettype wire

// *** testbench/afc_frontend_test.sv ***
/*
 Self-checking bench of the converter front-end control block.
 Assumes short divider counts so calibrations finish in a few hundred cycles.
*/
`default_nettype none
module afc_frontend_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MD = 4;
    localparam int CM = 8;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    afc_pkg::afc_bus_t bus = '0;
    logic [7:0]        rdat;
    logic              bpin = 1'b0;
    logic              sopen = 1'b0;
    logic              mbit = 1'b0;
    logic [7:0]        dio_in = 8'h00;
    afc_pkg::afc_dio_t pin_data_value;
    logic              sclk, clock_polarity_select, sdin, cs_n, rdy_n, bpos, bneg, buf_on, oneg;
    logic [7:0]        gfac;
    logic [6:0]        omag;
    logic [23:0]       gcoef;
    logic [23:0]       res;
    logic              cal_int;
    logic [7:0]        d;
    logic [23:0]       g;
    int                n;
    int                errors = 0;
    int                total_checks = 0;

    always #20 mclk = ~mclk;

    afc_frontend #(.MOD_DIV(MD), .CONV_MOD(CM)) afc_frontend_inst (
        .mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .bus_i(bus), .rd_data_o(rdat),
        .buf_pin_i(bpin), .sensor_open_i(sopen), .mod_bit_i(mbit), .dio_i(dio_in),
        .dio_o(pin_data_value), .sclk_i(sclk), .pol_i(clock_polarity_select), .sdin_i(sdin), .cs_n_i(cs_n),
        .result_ready_n_o(rdy_n), .burnout_pos_o(bpos), .burnout_neg_o(bneg),
        .buffer_on_o(buf_on), .gain_factor_o(gfac), .offset_neg_o(oneg),
        .offset_mag_o(omag), .cal_internal_o(cal_int), .result_o(res), .gain_coef_o(gcoef));

    afc_host_model afc_host_model_inst (
        .mclk_i(mclk), .sclk_o(sclk), .sdin_o(sdin), .cs_n_o(cs_n), .pol_o(clock_polarity_select));

    // ==========================================================
    // Bus and check helpers
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        v = rdat;
    endtask : rd

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic wait_rdy(output int cnt);
        cnt = 0;
        while (rdy_n !== 1'b0)
        begin
            @(posedge mclk);
            #1;
            cnt++;
            if (cnt > 3000)
            begin
                errors++;
                $display("unexpected at %0t: ready never came", $time);
                wrap_up();
            end
        end
    endtask : wait_rdy

    // ==========================================================
    // Calibration with measured duration
    task automatic cal(input logic [7:0] cmd, input logic sp, input logic [1:0] rt, input int per);
        int exp;
        int tol;
        exp = per * (CM << rt) * (MD << sp);
        tol = 2 * (MD << sp) + 4;
        wr(afc_pkg::A_SETUP, 8'h00);
        wr(afc_pkg::A_OFS, 8'h00);
        wr(afc_pkg::A_ACR, {2'h0, sp, 3'h0, rt});
        mbit <= (cmd == afc_pkg::CMD_SELF_GAIN);
        wr(afc_pkg::A_CMD, cmd);
        #1;
        chk(rdy_n, 1'b1);
        chk(cal_int, cmd <= afc_pkg::CMD_SELF_OFS);
        wait_rdy(n);
        chk(n >= exp - tol && n <= exp + tol, 1);
        rd(afc_pkg::A_RES0, d);
    endtask : cal

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(rdy_n, 1'b1);
        chk(pin_data_value, 16'h0000);
        chk(gfac, 8'h01);
        chk({bpos, bneg}, 2'b00);
        rd(afc_pkg::A_FUNC, d);
        chk(d, 8'h00);
        rd(afc_pkg::A_DIR, d);
        chk(d, 8'hFF);
        rd(4'h1, d);
        chk(d, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            wr(afc_pkg::A_SETUP, {5'h01, i[2:0]});
            settle();
            chk(gfac, 8'h01 << i);
            chk({bpos, bneg}, 2'b11);
        end
        wr(afc_pkg::A_SETUP, 8'h00);
        settle();
        chk({bpos, bneg}, 2'b00);
        for (int i = 0; i < 4; i++)
        begin
            bpin <= i[1];
            wr(afc_pkg::A_ACR, {3'h0, i[0], 4'h0});
            repeat (5) @(posedge mclk);
            #1;
            chk(buf_on, i[1] & i[0]);
        end
        wr(afc_pkg::A_OFS, 8'h85);
        settle();
        chk({oneg, omag}, 8'h85);
        wr(afc_pkg::A_OFS, 8'h7F);
        settle();
        chk({oneg, omag}, 8'h7F);
        dio_in <= 8'h3C;
        wr(afc_pkg::A_DIR, 8'h00);
        wr(afc_pkg::A_DIO, 8'hA5);
        settle();
        chk(pin_data_value, 16'h0000);
        wr(afc_pkg::A_FUNC, 8'hFF);
        settle();
        chk(pin_data_value, 16'hFFA5);
        wr(afc_pkg::A_DIR, 8'hFF);
        settle();
        chk(pin_data_value.oe, 8'h00);
        rd(afc_pkg::A_DIO, d);
        chk(d, 8'h3C);
        // The first result may precede the synchronised open flag
        wr(afc_pkg::A_SETUP, 8'h08);
        sopen <= 1'b1;
        // Let the open flag pass its synchroniser before the stale result is flushed
        settle();
        wait_rdy(n);
        rd(afc_pkg::A_RES0, d);
        wait_rdy(n);
        rd(afc_pkg::A_ACR, d);
        chk(d[7], 1'b0);
        rd(afc_pkg::A_RES2, d);
        chk(d, 8'h7F);
        rd(afc_pkg::A_RES1, d);
        chk(d, 8'hFF);
        rd(afc_pkg::A_RES0, d);
        chk(d, 8'hFF);
        chk(res, afc_pkg::FULL_SCALE);
        chk(rdy_n, 1'b1);
        rd(afc_pkg::A_ACR, d);
        chk(d[7], 1'b1);
        sopen <= 1'b0;
        cal(afc_pkg::CMD_SELF_GAIN, 1'b0, 2'h0, 2);
        g = gcoef;
        chk(g !== 24'h0, 1);
        cal(afc_pkg::CMD_SELF_OFS, 1'b0, 2'h1, 2);
        chk(gcoef, g);
        cal(afc_pkg::CMD_SYS_OFS, 1'b0, 2'h2, 2);
        chk(gcoef, g);
        cal(afc_pkg::CMD_SYS_GAIN, 1'b1, 2'h0, 2);
        cal(afc_pkg::CMD_SELF_FULL, 1'b0, 2'h0, 4);
        for (int p = 0; p < 2; p++)
        begin
            afc_host_model_inst.send(p[0], p[0] ? 8'h59 : 8'hA6);
            settle();
            rd(afc_pkg::A_SPI, d);
            chk(d, p[0] ? 8'h59 : 8'hA6);
        end
        wrap_up();
    end
endmodule : afc_frontend_test
`default_nettype wire
